// File: cfp_map.svh
// Constants for the current fault protection block
// Operation
// - Overcurrent past trip delay turns switch off, lowers overcurrent flag.
// - Overcurrent indication clears when switch command goes low.
// - Next high command after overcurrent cutoff turns switch on normally.
// - Delayed overcurrent detect races undelayed higher short detect.
// - Delayed overcurrent winning the race means cycle-by-cycle cutoff.
// - Short detect winning the race means a short-circuit fault.
// - Short-circuit turn-off uses reduced drive strength.
// - Short latch holds switch off until long low command or power removal.
// - Outputs high normally; overcurrent lowers one; short lowers both.
// - General fault output stays low until the short latch resets.
`ifndef CFP_MAP_SVH
`define CFP_MAP_SVH
// Clock period in ns (40 MHz); counts in ns keep the sums inside 32 bits
`define CFP_CLK_NS 25
// Overcurrent trip delay in ns and its cycle count, least time rounds up
`define CFP_TRIP_DELAY_NS 50
`define CFP_TRIP_CYC ((`CFP_TRIP_DELAY_NS+`CFP_CLK_NS-1)/`CFP_CLK_NS)
// Comparison window in ns and its cycle count, rounded up
`define CFP_WINDOW_NS 75
`define CFP_WINDOW_CYC ((`CFP_WINDOW_NS+`CFP_CLK_NS-1)/`CFP_CLK_NS)
// Short latch reset hold time in ns and its cycle count, rounded up
`define CFP_RESET_HOLD_NS 350000
`define CFP_RESET_CYC ((`CFP_RESET_HOLD_NS+`CFP_CLK_NS-1)/`CFP_CLK_NS)
// Output reset values
`define CFP_FLAG_IDLE 1'h1
`endif

// File: cfp_pkg.sv
// Types of the current fault protection block
`default_nettype none
package cfp_pkg;
	// Switch drive state
	typedef enum logic [1:0] {
		CFP_OFF = 2'b00,
		CFP_ON = 2'b01,
		CFP_OC_CUT = 2'b10,
		CFP_SC_LATCH = 2'b11
	} cfp_state_t;
endpackage
`default_nettype wire

// File: cfp_delay.sv
// Delay line for a comparator level, one stage per clock
`default_nettype none
module cfp_delay #(
	parameter int DEPTH = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Level in, and delayed level ANDed with the current level out
	input wire logic din,
	output logic dout
);
	logic [DEPTH-1:0] tap_ff;

	// Shift the level along the taps; clears on reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tap_ff <= '0;
		end else begin
			tap_ff <= {tap_ff[DEPTH-2:0], din};
		end
	end

	assign dout = tap_ff[DEPTH-1] & din;
endmodule
`default_nettype wire

// File: cfp_top.sv
// Current fault protection: overcurrent cutoff and short-circuit latch
`default_nettype none
`include "cfp_map.svh"
module cfp_top #(
	parameter int TRIP_CYC = `CFP_TRIP_CYC,
	parameter int WINDOW_CYC = `CFP_WINDOW_CYC,
	parameter int RESET_CYC = `CFP_RESET_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Controller command and comparator pins
	input wire logic switch_cmd,
	input wire logic oc_cmp,
	input wire logic sc_cmp,
	// Gate drive
	output logic gate_on,
	output logic drive_weak,
	// Fault reporting, active low
	output logic fault_n,
	output logic overcurrent_flag_n,
	// Current state for observation
	output cfp_pkg::cfp_state_t drive_state
);
	import cfp_pkg::*;

	localparam int RW = $clog2(RESET_CYC + 1);
	localparam int TW = $clog2(TRIP_CYC + 1);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [1:0] cmd_s_ff, oc_s_ff, sc_s_ff;

	// Two flops per pin before any logic looks at it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_s_ff <= 2'h0;
			oc_s_ff <= 2'h0;
			sc_s_ff <= 2'h0;
		end else begin
			cmd_s_ff <= {cmd_s_ff[0], switch_cmd};
			oc_s_ff <= {oc_s_ff[0], oc_cmp};
			sc_s_ff <= {sc_s_ff[0], sc_cmp};
		end
	end

	logic cmd, oc, sc;
	assign cmd = cmd_s_ff[1];
	assign oc = oc_s_ff[1];
	assign sc = sc_s_ff[1];

	// ************************************************************
	// Race between delayed overcurrent and short detection
	// ************************************************************
	logic oc_late;

	// Overcurrent detect delayed by the comparison window
	cfp_delay #(.DEPTH(WINDOW_CYC)) u_window (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din(oc),
		.dout(oc_late)
	);

	// Trip delay counter after overcurrent crossing
	logic [TW-1:0] trip_cnt_ff;
	logic trip;
	always_ff @(posedge core_clk) begin
		if (!rst_n || !oc || !cmd) begin
			trip_cnt_ff <= '0;
		end else if (trip_cnt_ff != TW'(TRIP_CYC)) begin
			trip_cnt_ff <= trip_cnt_ff + TW'(1);
		end
	end
	assign trip = oc && trip_cnt_ff == TW'(TRIP_CYC);

	// ************************************************************
	// Latch reset timer
	// ************************************************************
	logic [RW-1:0] low_cnt_ff;
	logic low_long;

	// Counts continuous low command; any high restarts
	always_ff @(posedge core_clk) begin
		if (!rst_n || cmd) begin
			low_cnt_ff <= '0;
		end else if (low_cnt_ff != RW'(RESET_CYC)) begin
			low_cnt_ff <= low_cnt_ff + RW'(1);
		end
	end
	assign low_long = low_cnt_ff == RW'(RESET_CYC);

	// ************************************************************
	// Drive state machine
	// ************************************************************
	cfp_state_t state_ff, nxt_state;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			CFP_OFF: begin
				if (cmd) nxt_state = CFP_ON;
			end
			CFP_ON: begin
				if (!cmd) nxt_state = CFP_OFF;
				else if (sc && !oc_late) nxt_state = CFP_SC_LATCH;
				else if (oc_late || trip) nxt_state = CFP_OC_CUT;
			end
			CFP_OC_CUT: begin
				if (sc && !oc_late) nxt_state = CFP_SC_LATCH;
				else if (!cmd) nxt_state = CFP_OFF;
			end
			CFP_SC_LATCH: begin
				if (low_long) nxt_state = CFP_OFF;
			end
		endcase
	end

	// Power removal is modelled by rst_n
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= CFP_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			gate_on <= 1'h0;
			drive_weak <= 1'h0;
			fault_n <= `CFP_FLAG_IDLE;
			overcurrent_flag_n <= `CFP_FLAG_IDLE;
			drive_state <= CFP_OFF;
		end else begin
			gate_on <= nxt_state == CFP_ON;
			drive_weak <= nxt_state == CFP_SC_LATCH;
			fault_n <= nxt_state != CFP_SC_LATCH;
			overcurrent_flag_n <= !(nxt_state == CFP_OC_CUT ||
				nxt_state == CFP_SC_LATCH);
			drive_state <= nxt_state;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_short_holds_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_SC_LATCH && !low_long |=> !gate_on)
		else $error("gate on during short latch");

	a_short_both_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_SC_LATCH |-> !fault_n && !overcurrent_flag_n
		&& drive_weak)
		else $error("short outputs wrong");

	a_oc_flag_only: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_OC_CUT |-> fault_n && !overcurrent_flag_n
		&& !gate_on)
		else $error("overcurrent outputs wrong");

	a_oc_clears_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_OC_CUT && !cmd && !sc |=> overcurrent_flag_n)
		else $error("overcurrent flag not cleared");

	a_restart_after_oc: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		drive_state == CFP_OFF && cmd |=> gate_on)
		else $error("no restart after overcurrent");

	a_race_short: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_ON && cmd && sc && !oc_late
		|=> drive_state == CFP_SC_LATCH)
		else $error("short not latched");

	a_race_oc: assert property (@(posedge core_clk) disable iff (!rst_n)
		drive_state == CFP_ON && cmd && oc_late
		|=> drive_state == CFP_OC_CUT)
		else $error("overcurrent not classified");

	a_release_long_low: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		drive_state == CFP_SC_LATCH && cmd |=> low_cnt_ff == '0)
		else $error("low count not restarted");

	a_window_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
		oc_late |-> $past(oc, WINDOW_CYC) && oc)
		else $error("window delay wrong");
endmodule
`default_nettype wire

// File: cfp_ctrl_model.sv
// Converter controller model: switch command out, fault pair decoded in
`default_nettype none
module cfp_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Bench request and command to the block
	input wire logic want_on,
	output logic switch_cmd,
	// Fault pair in, decoded kind out: 0 normal, 1 overcurrent, 3 short
	input wire logic fault_n,
	input wire logic overcurrent_flag_n,
	output logic [1:0] fault_kind
);
	timeunit 1ns;
	timeprecision 1ps;
	// Command follows the request; a long low request clears a short
	initial switch_cmd = 1'b0;
	always @(posedge core_clk) switch_cmd <= want_on;
	// Both outputs are read together to tell the fault type
	assign fault_kind = {~fault_n, ~overcurrent_flag_n};
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the current fault protection block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cfp_pkg::*;
	localparam int RST_CYC = 20;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic want_on = 1'b0;
	logic oc_cmp = 1'b0;
	logic sc_cmp = 1'b0;
	logic switch_cmd, gate_on, drive_weak, fault_n, overcurrent_flag_n;
	logic [1:0] fault_kind;
	cfp_state_t drive_state;
	int fail_count = 0;
	int samples_checked = 0;
	// Clock of 25 ns
	always #12.5 core_clk = ~core_clk;
	cfp_top #(.TRIP_CYC(2), .WINDOW_CYC(3), .RESET_CYC(RST_CYC)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .switch_cmd(switch_cmd),
		.oc_cmp(oc_cmp), .sc_cmp(sc_cmp), .gate_on(gate_on),
		.drive_weak(drive_weak), .fault_n(fault_n),
		.overcurrent_flag_n(overcurrent_flag_n), .drive_state(drive_state));
	cfp_ctrl_model ctrl (.core_clk(core_clk), .want_on(want_on),
		.switch_cmd(switch_cmd), .fault_n(fault_n),
		.overcurrent_flag_n(overcurrent_flag_n), .fault_kind(fault_kind));
	// Compare and count
	task automatic chk(input string name, input logic [1:0] got,
			input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	// Let edges pass, then sample settled outputs
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Drive request and comparators at a rising edge
	task automatic drv(input logic w, input logic o, input logic s);
		@(posedge core_clk);
		want_on <= w;
		oc_cmp <= o;
		sc_cmp <= s;
	endtask
	// Reset values, then release
	task automatic t_reset();
		tick(4);
		chk("gate", gate_on, 2'h0);
		chk("weak", drive_weak, 2'h0);
		chk("kind", fault_kind, 2'h0);
		chk("state", drive_state, CFP_OFF);
		@(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	// Overcurrent cut, clear on low command, next cycle normal
	task automatic t_overcurrent();
		drv(1'b1, 1'b0, 1'b0);
		tick(6);
		chk("gate", gate_on, 2'h1);
		drv(1'b1, 1'b1, 1'b0);
		tick(8);
		chk("gate", gate_on, 2'h0);
		chk("kind", fault_kind, 2'h1);
		chk("weak", drive_weak, 2'h0);
		chk("state", drive_state, CFP_OC_CUT);
		drv(1'b0, 1'b0, 1'b0);
		tick(6);
		chk("kind", fault_kind, 2'h0);
		drv(1'b1, 1'b0, 1'b0);
		tick(6);
		chk("gate", gate_on, 2'h1);
	endtask
	// Short wins the race, latches, interrupted low does not clear
	task automatic t_short();
		drv(1'b1, 1'b1, 1'b1);
		tick(6);
		chk("kind", fault_kind, 2'h3);
		chk("weak", drive_weak, 2'h1);
		chk("gate", gate_on, 2'h0);
		drv(1'b1, 1'b0, 1'b0);
		tick(6);
		chk("gate", gate_on, 2'h0);
		drv(1'b0, 1'b0, 1'b0);
		tick(10);
		drv(1'b1, 1'b0, 1'b0);
		tick(3);
		drv(1'b0, 1'b0, 1'b0);
		tick(RST_CYC - 5);
		chk("kind", fault_kind, 2'h3);
		tick(15);
		chk("kind", fault_kind, 2'h0);
		chk("weak", drive_weak, 2'h0);
		drv(1'b1, 1'b0, 1'b0);
		tick(6);
		chk("gate", gate_on, 2'h1);
	endtask
	// Power removal clears a latched short
	task automatic t_power();
		drv(1'b1, 1'b1, 1'b1);
		tick(6);
		chk("kind", fault_kind, 2'h3);
		drv(1'b0, 1'b0, 1'b0);
		rst_n <= 1'b0;
		tick(2);
		@(posedge core_clk);
		rst_n <= 1'b1;
		tick(2);
		chk("kind", fault_kind, 2'h0);
	endtask
	// Counts and verdict
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		t_reset();
		t_overcurrent();
		t_short();
		t_power();
		report_and_stop();
	end
	// Watchdog
	initial begin
		#(3000 * 25);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
